// file: src/csl_status_led.sv
// Camera status lamp controller with APB register access
//
// Summary of operation
// - Only the highest-priority active condition is shown; acquisition beats address assigned.
// - Lamp is steady red from reset until the power-up phase ends.
// - Steady red afterwards only for a fatal error before initialisation completes.
// - Red flashes while initialisation is running.
// - Fatal error after initialisation completes shows red plus flashing blue; restart is requested in under a minute.
// - Cable disconnected: slow blue flashing and periodic address retry requests.
// - File transfer active: fast blue flashing.
// - Address assigned, no application: steady blue.
// - Application connected, no acquisition: steady green.
// - Acquisition: one green flash per frame arriving at least 100 ms after the last flash; other frames are dropped.
// - After power-up red, blue flashes while waiting for address configuration.
`default_nettype none
module csl_status_led
    import csl_pkg::*;
#(
    parameter int unsigned POWERUP_CYC = CSL_POWERUP_CYC,
    parameter int unsigned SLOW_HALF_CYC = CSL_SLOW_HALF_CYC,
    parameter int unsigned FAST_HALF_CYC = CSL_FAST_HALF_CYC,
    parameter int unsigned ACQ_GAP_CYC = CSL_ACQ_GAP_CYC,
    parameter int unsigned ACQ_ON_CYC = CSL_ACQ_ON_CYC,
    parameter int unsigned RESTART_CYC = CSL_RESTART_CYC,
    parameter int unsigned RETRY_CYC = CSL_RETRY_CYC
)(
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic initRunning,
    input wire logic initDone,
    input wire logic fatalError,
    input wire logic linkUp,
    input wire logic fileTransfer,
    input wire logic ipAssigned,
    input wire logic appConnected,
    input wire logic acqActive,
    input wire logic frameStrobe,
    output logic ledRed,
    output logic ledGreen,
    output logic ledBlue,
    output logic restartReq,
    output logic ipRetryReq,
    output logic irq
);
    typedef struct packed {
        csl_mode_e mode;
        logic puDone;
        logic [31:0] puCnt;
        logic [31:0] acqCnt;
        logic [31:0] rstCnt;
        logic [31:0] tryCnt;
        logic [CSL_CTRL_W-1:0] ctrl;
        logic [CSL_EV_W-1:0] status;
        logic [CSL_EV_W-1:0] mask;
        logic ledRed;
        logic ledGreen;
        logic ledBlue;
        logic restartReq;
        logic ipRetryReq;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } csl_state_s;

    localparam csl_state_s ST_RST = '{
        mode: CSL_MODE_POWERUP,
        puDone: 1'b0,
        puCnt: 32'h0000_0000,
        acqCnt: 32'h0000_0000,
        rstCnt: 32'h0000_0000,
        tryCnt: 32'h0000_0000,
        ctrl: CSL_CTRL_RST,
        status: CSL_STATUS_RST,
        mask: CSL_MASK_RST,
        ledRed: CSL_RED_RST,
        ledGreen: 1'b0,
        ledBlue: 1'b0,
        restartReq: 1'b0,
        ipRetryReq: 1'b0,
        irq: 1'b0,
        prdata: 32'h0000_0000,
        pready: 1'b0,
        pslverr: 1'b0
    };

    csl_state_s st_r;
    csl_state_s st_nxt;
    logic slowPhase;
    logic fastPhase;

    // Two distinct flash rates from the system clock
    csl_tick #(.HALF_CYC(SLOW_HALF_CYC)) uSlow (
        .clock(clock),
        .reset(reset),
        .phase(slowPhase)
    );

    csl_tick #(.HALF_CYC(FAST_HALF_CYC)) uFast (
        .clock(clock),
        .reset(reset),
        .phase(fastPhase)
    );

    always_comb
    begin
        logic [CSL_EV_W-1:0] events;
        logic accessWr;
        events = '0;
        accessWr = 1'b0;
        st_nxt = st_r;
        st_nxt.restartReq = 1'b0;
        st_nxt.ipRetryReq = 1'b0;

        // Power-up phase holds the lamp red before any pattern
        if (!st_r.puDone)
        begin
            if (st_r.puCnt == 32'(POWERUP_CYC - 1))
            begin
                st_nxt.puDone = 1'b1;
            end
            else
            begin
                st_nxt.puCnt = st_r.puCnt + 32'h0000_0001;
            end
        end

        // Fixed priority, highest first
        if (!st_r.puDone)
            st_nxt.mode = CSL_MODE_POWERUP;
        else if (fatalError && !initDone)
            st_nxt.mode = CSL_MODE_FATAL_HALT;
        else if (fatalError)
            st_nxt.mode = CSL_MODE_FATAL_BLINK;
        else if (initRunning || !initDone)
            st_nxt.mode = CSL_MODE_INIT;
        else if (!linkUp)
            st_nxt.mode = CSL_MODE_LINK_LOST;
        else if (fileTransfer)
            st_nxt.mode = CSL_MODE_XFER;
        else if (!ipAssigned)
            st_nxt.mode = CSL_MODE_WAIT_IP;
        else if (acqActive)
            st_nxt.mode = CSL_MODE_ACQ;
        else if (appConnected)
            st_nxt.mode = CSL_MODE_APP;
        else
            st_nxt.mode = CSL_MODE_IP_OK;
        if (st_nxt.mode != st_r.mode)
            events[CSL_EV_MODE] = 1'b1;

        // Frame flashes: a frame inside the gap is dropped, not queued
        if (frameStrobe && st_nxt.mode == CSL_MODE_ACQ && st_r.acqCnt == 32'h0000_0000)
            st_nxt.acqCnt = 32'(ACQ_GAP_CYC - 1);
        else if (st_r.acqCnt != 32'h0000_0000)
            st_nxt.acqCnt = st_r.acqCnt - 32'h0000_0001;
        if (frameStrobe && st_nxt.mode == CSL_MODE_ACQ && st_r.acqCnt != 32'h0000_0000)
            events[CSL_EV_THROTTLE] = 1'b1;

        // Self-restart request, repeated while the error stays
        if ((st_nxt.mode == CSL_MODE_FATAL_HALT || st_nxt.mode == CSL_MODE_FATAL_BLINK)
            && st_r.ctrl[CSL_CTRL_RESTART_BIT])
        begin
            if (st_r.rstCnt == 32'(RESTART_CYC - 1))
            begin
                st_nxt.rstCnt = 32'h0000_0000;
                st_nxt.restartReq = 1'b1;
                events[CSL_EV_RESTART] = 1'b1;
            end
            else
            begin
                st_nxt.rstCnt = st_r.rstCnt + 32'h0000_0001;
            end
        end
        else
        begin
            st_nxt.rstCnt = 32'h0000_0000;
        end

        // Address retry while the cable is out
        if (st_nxt.mode == CSL_MODE_LINK_LOST && st_r.ctrl[CSL_CTRL_RETRY_BIT])
        begin
            if (st_r.tryCnt == 32'(RETRY_CYC - 1))
            begin
                st_nxt.tryCnt = 32'h0000_0000;
                st_nxt.ipRetryReq = 1'b1;
                events[CSL_EV_RETRY] = 1'b1;
            end
            else
            begin
                st_nxt.tryCnt = st_r.tryCnt + 32'h0000_0001;
            end
        end
        else
        begin
            st_nxt.tryCnt = 32'h0000_0000;
        end

        // Lamp colours follow the mode being entered
        st_nxt.ledRed = 1'b0;
        st_nxt.ledGreen = 1'b0;
        st_nxt.ledBlue = 1'b0;
        case (st_nxt.mode)
            CSL_MODE_POWERUP: st_nxt.ledRed = 1'b1;
            CSL_MODE_FATAL_HALT: st_nxt.ledRed = 1'b1;
            CSL_MODE_FATAL_BLINK:
            begin
                st_nxt.ledRed = 1'b1;
                st_nxt.ledBlue = slowPhase;
            end
            CSL_MODE_INIT: st_nxt.ledRed = slowPhase;
            CSL_MODE_LINK_LOST: st_nxt.ledBlue = slowPhase;
            CSL_MODE_XFER: st_nxt.ledBlue = fastPhase;
            CSL_MODE_WAIT_IP: st_nxt.ledBlue = slowPhase;
            CSL_MODE_ACQ: st_nxt.ledGreen = (st_nxt.acqCnt != 32'h0000_0000)
                && (st_nxt.acqCnt >= 32'(ACQ_GAP_CYC - ACQ_ON_CYC));
            CSL_MODE_APP: st_nxt.ledGreen = 1'b1;
            CSL_MODE_IP_OK: st_nxt.ledBlue = 1'b1;
            default: st_nxt.ledRed = 1'b1;
        endcase

        // APB: read data and error are prepared in the setup cycle
        st_nxt.pready = psel && !penable;
        st_nxt.pslverr = 1'b0;
        st_nxt.prdata = 32'h0000_0000;
        if (psel && !penable)
        begin
            case (paddr)
                CSL_OFS_CTRL: st_nxt.prdata = 32'(st_r.ctrl);
                CSL_OFS_STATE:
                begin
                    st_nxt.prdata[CSL_STATE_MODE_LSB +: 4] = st_r.mode;
                    st_nxt.prdata[CSL_STATE_RED_BIT] = st_r.ledRed;
                    st_nxt.prdata[CSL_STATE_GREEN_BIT] = st_r.ledGreen;
                    st_nxt.prdata[CSL_STATE_BLUE_BIT] = st_r.ledBlue;
                    st_nxt.prdata[CSL_STATE_PUDONE_BIT] = st_r.puDone;
                end
                CSL_OFS_IRQ_STATUS: st_nxt.prdata = 32'(st_r.status);
                CSL_OFS_IRQ_MASK: st_nxt.prdata = 32'(st_r.mask);
                default: st_nxt.pslverr = 1'b1;
            endcase
        end
        accessWr = psel && penable && pwrite && st_r.pready;
        st_nxt.status = st_r.status | events;
        if (accessWr)
        begin
            case (paddr)
                CSL_OFS_CTRL: st_nxt.ctrl = pwdata[CSL_CTRL_W-1:0];
                CSL_OFS_IRQ_MASK: st_nxt.mask = pwdata[CSL_EV_W-1:0];
                // Write one to clear; a new event in the same cycle survives
                CSL_OFS_IRQ_STATUS: st_nxt.status = (st_r.status & ~pwdata[CSL_EV_W-1:0]) | events;
                default: st_nxt.status = st_r.status | events;
            endcase
        end
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            st_r <= ST_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign ledRed = st_r.ledRed;
    assign ledGreen = st_r.ledGreen;
    assign ledBlue = st_r.ledBlue;
    assign restartReq = st_r.restartReq;
    assign ipRetryReq = st_r.ipRetryReq;
    assign irq = st_r.irq;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence s_allUp;
        st_r.puDone && !fatalError && initDone && !initRunning && linkUp && !fileTransfer && ipAssigned;
    endsequence

    sequence s_leavePowerup;
        st_r.mode == CSL_MODE_POWERUP ##1 st_r.mode == CSL_MODE_WAIT_IP;
    endsequence

    property p_acqOverIp;
        s_allUp and (acqActive && appConnected) |=> st_r.mode == CSL_MODE_ACQ;
    endproperty
    a_acqOverIp: assert property (p_acqOverIp) else $error("acquisition not shown over lower conditions");

    property p_powerupRed;
        !st_r.puDone |=> ledRed && !ledGreen && !ledBlue;
    endproperty
    a_powerupRed: assert property (p_powerupRed) else $error("lamp not steady red in power-up phase");

    property p_fatalHalt;
        st_r.puDone && fatalError && !initDone |=> ledRed && !ledBlue && !ledGreen
            && st_r.mode == CSL_MODE_FATAL_HALT;
    endproperty
    a_fatalHalt: assert property (p_fatalHalt) else $error("fatal error before init not steady red");

    property p_initFlash;
        st_r.mode == CSL_MODE_INIT |-> ledRed == $past(slowPhase) && !ledBlue && !ledGreen;
    endproperty
    a_initFlash: assert property (p_initFlash) else $error("init mode does not flash red");

    property p_fatalBlink;
        st_r.mode == CSL_MODE_FATAL_BLINK |-> ledRed && ledBlue == $past(slowPhase) && !ledGreen;
    endproperty
    a_fatalBlink: assert property (p_fatalBlink) else $error("fatal error not red with flashing blue");

    property p_restartCause;
        restartReq |-> st_r.mode == CSL_MODE_FATAL_HALT || st_r.mode == CSL_MODE_FATAL_BLINK;
    endproperty
    a_restartCause: assert property (p_restartCause) else $error("restart requested without fatal error");

    property p_linkLost;
        st_r.mode == CSL_MODE_LINK_LOST |-> ledBlue == $past(slowPhase) && !ledRed && !ledGreen;
    endproperty
    a_linkLost: assert property (p_linkLost) else $error("link loss does not flash blue slowly");

    property p_xfer;
        st_r.mode == CSL_MODE_XFER |-> ledBlue == $past(fastPhase) && !ledRed && !ledGreen;
    endproperty
    a_xfer: assert property (p_xfer) else $error("file transfer does not flash blue fast");

    property p_ipOk;
        s_allUp and (!acqActive && !appConnected) |=> ledBlue && !ledRed && !ledGreen;
    endproperty
    a_ipOk: assert property (p_ipOk) else $error("assigned address not steady blue");

    property p_app;
        s_allUp and (!acqActive && appConnected) |=> ledGreen && !ledRed && !ledBlue;
    endproperty
    a_app: assert property (p_app) else $error("connected application not steady green");

    property p_frameGap;
        st_r.mode == CSL_MODE_ACQ && $rose(ledGreen) |-> $past(st_r.acqCnt) == 32'h0000_0000;
    endproperty
    a_frameGap: assert property (p_frameGap) else $error("green flash inside the minimum gap");

    property p_waitIpBlue;
        s_leavePowerup |-> ledBlue == $past(slowPhase) && !ledRed;
    endproperty
    a_waitIpBlue: assert property (p_waitIpBlue) else $error("no flashing blue after power-up red");
endmodule : csl_status_led
`default_nettype wire

// file: pkg/csl_pkg.sv
// Constants, register map and types for the camera status lamp controller
`default_nettype none
package csl_pkg;
    // Clock rate and times in their own units
    localparam int unsigned CSL_CLK_KHZ = 50000;
    localparam int unsigned CSL_POWERUP_MS = 200;
    localparam int unsigned CSL_SLOW_HALF_MS = 500;
    localparam int unsigned CSL_FAST_HALF_MS = 100;
    localparam int unsigned CSL_ACQ_GAP_MS = 100;
    localparam int unsigned CSL_ACQ_ON_MS = 50;
    localparam int unsigned CSL_RESTART_MS = 30000;
    localparam int unsigned CSL_RETRY_MS = 1000;

    // Derived cycle counts
    localparam int unsigned CSL_POWERUP_CYC = CSL_POWERUP_MS * CSL_CLK_KHZ;
    localparam int unsigned CSL_SLOW_HALF_CYC = CSL_SLOW_HALF_MS * CSL_CLK_KHZ;
    localparam int unsigned CSL_FAST_HALF_CYC = CSL_FAST_HALF_MS * CSL_CLK_KHZ;
    localparam int unsigned CSL_ACQ_GAP_CYC = CSL_ACQ_GAP_MS * CSL_CLK_KHZ;
    localparam int unsigned CSL_ACQ_ON_CYC = CSL_ACQ_ON_MS * CSL_CLK_KHZ;
    localparam int unsigned CSL_RESTART_CYC = CSL_RESTART_MS * CSL_CLK_KHZ;
    localparam int unsigned CSL_RETRY_CYC = CSL_RETRY_MS * CSL_CLK_KHZ;

    // Register byte offsets
    localparam logic [7:0] CSL_OFS_CTRL = 8'h00;
    localparam logic [7:0] CSL_OFS_STATE = 8'h04;
    localparam logic [7:0] CSL_OFS_IRQ_STATUS = 8'h08;
    localparam logic [7:0] CSL_OFS_IRQ_MASK = 8'h0C;

    // Control fields
    localparam int CSL_CTRL_W = 2;
    localparam int CSL_CTRL_RESTART_BIT = 0;
    localparam int CSL_CTRL_RETRY_BIT = 1;
    localparam logic [CSL_CTRL_W-1:0] CSL_CTRL_RST = 2'h3;

    // State read-back fields
    localparam int CSL_STATE_MODE_LSB = 0;
    localparam int CSL_STATE_BLUE_BIT = 4;
    localparam int CSL_STATE_GREEN_BIT = 5;
    localparam int CSL_STATE_RED_BIT = 6;
    localparam int CSL_STATE_PUDONE_BIT = 7;

    // Event bits, shared by status and mask
    localparam int CSL_EV_W = 4;
    localparam int CSL_EV_MODE = 0;
    localparam int CSL_EV_RESTART = 1;
    localparam int CSL_EV_THROTTLE = 2;
    localparam int CSL_EV_RETRY = 3;
    localparam logic [CSL_EV_W-1:0] CSL_STATUS_RST = 4'h0;
    localparam logic [CSL_EV_W-1:0] CSL_MASK_RST = 4'h0;

    // Lamp state at power-up: steady red
    localparam logic CSL_RED_RST = 1'b1;

    typedef enum logic [3:0] {
        CSL_MODE_POWERUP = 4'h0,
        CSL_MODE_INIT = 4'h1,
        CSL_MODE_WAIT_IP = 4'h3,
        CSL_MODE_IP_OK = 4'h2,
        CSL_MODE_APP = 4'h6,
        CSL_MODE_ACQ = 4'h7,
        CSL_MODE_LINK_LOST = 4'h5,
        CSL_MODE_XFER = 4'h4,
        CSL_MODE_FATAL_HALT = 4'hC,
        CSL_MODE_FATAL_BLINK = 4'hD
    } csl_mode_e;
endpackage : csl_pkg
`default_nettype wire

// file: src/csl_tick.sv
// Free-running square wave used as a flash phase
`default_nettype none
module csl_tick
    import csl_pkg::*;
#(
    parameter int unsigned HALF_CYC = CSL_SLOW_HALF_CYC
)(
    input wire logic clock,
    input wire logic reset,
    output logic phase
);
    typedef struct packed {
        logic [31:0] cnt;
        logic phase;
    } csl_tick_s;

    csl_tick_s st_r;
    csl_tick_s st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (st_r.cnt == 32'(HALF_CYC - 1))
        begin
            st_nxt.cnt = 32'h0000_0000;
            st_nxt.phase = !st_r.phase;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign phase = st_r.phase;

    property p_halfPeriod;
        @(posedge clock) disable iff (reset)
        $changed(phase) |-> st_r.cnt == 32'h0000_0000;
    endproperty
    a_halfPeriod: assert property (p_halfPeriod) else $error("flash phase toggled off its period");
endmodule : csl_tick
`default_nettype wire

// file: sim/csl_lamp_model.sv
// Behavioural multicolour lamp that counts colour changes for the bench
`default_nettype none
module csl_lamp_model
    import csl_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic clear,
    input wire logic red,
    input wire logic green,
    input wire logic blue,
    output logic [7:0] redEdges,
    output logic [7:0] blueEdges,
    output logic [7:0] greenRises
);
    timeunit 1ns;
    timeprecision 1ps;
    logic redPrev;
    logic greenPrev;
    logic bluePrev;
    // A real lamp has no memory; the counts only let the bench judge flash rates
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            redEdges <= 8'h00;
            blueEdges <= 8'h00;
            greenRises <= 8'h00;
        end
        else if (clear)
        begin
            redEdges <= 8'h00;
            blueEdges <= 8'h00;
            greenRises <= 8'h00;
        end
        else
        begin
            redEdges <= redEdges + 8'((red !== redPrev) ? 1 : 0);
            blueEdges <= blueEdges + 8'((blue !== bluePrev) ? 1 : 0);
            greenRises <= greenRises + 8'((green === 1'b1 && greenPrev !== 1'b1) ? 1 : 0);
        end
    end
    always_ff @(posedge clock)
    begin
        redPrev <= red;
        greenPrev <= green;
        bluePrev <= blue;
    end
endmodule : csl_lamp_model
`default_nettype wire

// file: sim/csl_status_led_bench.sv
// Self-checking bench for the camera status lamp controller
`default_nettype none
module csl_status_led_bench
    import csl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, lf = 32'h0000_3133;
    logic pready, pslverr, err, ledRed, ledGreen, ledBlue, restartReq, ipRetryReq, irq;
    logic initRunning = 1'b0, initDone = 1'b0, fatalError = 1'b0, linkUp = 1'b0;
    logic fileTransfer = 1'b0, ipAssigned = 1'b0, appConnected = 1'b0, acqActive = 1'b0;
    logic frameStrobe = 1'b0, lampClear = 1'b0;
    logic [7:0] redEdges, blueEdges, greenRises, c;
    int num_errors = 0, samples_checked = 0, nRestart = 0, nRetry = 0;

    // Shortened times keep every pattern inside a short run
    localparam int unsigned TB_POWERUP_CYC = 20;
    localparam int unsigned TB_SLOW_CYC = 8;
    localparam int unsigned TB_FAST_CYC = 3;
    localparam int unsigned TB_GAP_CYC = 12;
    localparam int unsigned TB_ON_CYC = 6;
    localparam int unsigned TB_RESTART_CYC = 40;
    localparam int unsigned TB_RETRY_CYC = 30;

    csl_status_led #(.POWERUP_CYC(TB_POWERUP_CYC), .SLOW_HALF_CYC(TB_SLOW_CYC), .FAST_HALF_CYC(TB_FAST_CYC),
        .ACQ_GAP_CYC(TB_GAP_CYC), .ACQ_ON_CYC(TB_ON_CYC), .RESTART_CYC(TB_RESTART_CYC),
        .RETRY_CYC(TB_RETRY_CYC)) u_dut (.clock, .reset, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .initRunning, .initDone, .fatalError,
        .linkUp, .fileTransfer, .ipAssigned, .appConnected, .acqActive, .frameStrobe, .ledRed,
        .ledGreen, .ledBlue, .restartReq, .ipRetryReq, .irq);
    csl_lamp_model u_lamp (.clock, .reset, .clear(lampClear), .red(ledRed), .green(ledGreen),
        .blue(ledBlue), .redEdges, .blueEdges, .greenRises);

    initial
    begin
        forever #10 clock = ~clock;
    end
    // Request counters restart with the lamp counts, so one process owns them
    always @(posedge clock)
    begin
        if (lampClear)
        begin
            nRestart <= 0;
            nRetry <= 0;
        end
        else
        begin
            nRestart <= nRestart + ((restartReq === 1'b1) ? 1 : 0);
            nRetry <= nRetry + ((ipRetryReq === 1'b1) ? 1 : 0);
        end
    end

    task automatic test_done();
        $display("Counts: %0d mismatches in %0d comparisons", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : chk

    // Holds the request until pready is sampled high at a rising edge, takes the answer and releases there
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 16)
        begin
            n++;
            @(posedge clock);
        end
        if (pready !== 1'b1)
        begin
            num_errors++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cond(input logic [7:0] v);
        @(posedge clock);
        initRunning <= v[7];
        initDone <= v[6];
        fatalError <= v[5];
        linkUp <= v[4];
        fileTransfer <= v[3];
        ipAssigned <= v[2];
        appConnected <= v[1];
        acqActive <= v[0];
        repeat (3) @(posedge clock);
    endtask : cond

    task automatic wait_count(input int cyc);
        @(posedge clock);
        lampClear <= 1'b1;
        @(posedge clock);
        lampClear <= 1'b0;
        repeat (cyc) @(posedge clock);
        @(negedge clock);
    endtask : wait_count

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Priority fatal, init, link, transfer, address, acq, app; bit 7 init running, 6 init done, 5 fatal, 4 link, 3 transfer, 2 address, 1 app, 0 acq
    function automatic csl_mode_e exp_mode(input logic [7:0] v);
        if (v[5] && !v[6]) return CSL_MODE_FATAL_HALT;
        if (v[5]) return CSL_MODE_FATAL_BLINK;
        if (v[7] || !v[6]) return CSL_MODE_INIT;
        if (!v[4]) return CSL_MODE_LINK_LOST;
        if (v[3]) return CSL_MODE_XFER;
        if (!v[2]) return CSL_MODE_WAIT_IP;
        if (v[0]) return CSL_MODE_ACQ;
        if (v[1]) return CSL_MODE_APP;
        return CSL_MODE_IP_OK;
    endfunction : exp_mode

    initial
    begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        apb(1'b0, CSL_OFS_CTRL, 32'h0000_0000);
        chk(rd === 32'h0000_0003, "control reset value");
        apb(1'b0, CSL_OFS_IRQ_MASK, 32'h0000_0000);
        chk(rd === 32'h0000_0000 && err === 1'b0, "mask reset value");
        apb(1'b1, 8'h10, 32'hFFFF_FFFF);
        chk(err === 1'b1, "unmapped write refused");
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk(err === 1'b1 && rd === 32'h0000_0000, "unmapped read refused");
        chk(ledRed === 1'b1 && ledGreen === 1'b0 && ledBlue === 1'b0, "power-up steady red");
        cond(8'h50);
        wait_count(64);
        chk(blueEdges >= 8'd7 && blueEdges <= 8'd9 && ledRed === 1'b0, "blue flash awaiting address");
        $display("Test power-up done");
        for (int i = 0; i < 40; i++)
        begin
            lf = lfsr(lf);
            c = (i < 8) ? (8'h57 ^ (8'h01 << i)) : lf[7:0];
            cond(c);
            apb(1'b0, CSL_OFS_STATE, 32'h0000_0000);
            chk(rd[3:0] === 4'(exp_mode(c)) && rd[7] === 1'b1, "mode priority");
            if (exp_mode(c) == CSL_MODE_FATAL_HALT)
                chk({ledRed, ledGreen, ledBlue} === 3'b100, "steady red on fatal");
            if (exp_mode(c) == CSL_MODE_IP_OK)
                chk({ledRed, ledGreen, ledBlue} === 3'b001, "steady blue");
            if (exp_mode(c) == CSL_MODE_APP)
                chk({ledRed, ledGreen, ledBlue} === 3'b010, "steady green");
        end
        $display("Test priority done");
        cond(8'h80);
        wait_count(64);
        chk(redEdges >= 8'd7 && redEdges <= 8'd9 && ledBlue === 1'b0, "init red flash");
        cond(8'h50 | 8'h08 | 8'h04);
        wait_count(64);
        chk(blueEdges >= 8'd20 && blueEdges <= 8'd22, "fast blue flash");
        cond(8'h60);
        wait_count(100);
        chk(redEdges === 8'd0 && ledRed === 1'b1 && blueEdges >= 8'd11, "fatal red plus blue");
        chk(nRestart >= 2 && nRestart <= 3, "restart requests");
        cond(8'h44);
        wait_count(100);
        chk(blueEdges >= 8'd11 && blueEdges <= 8'd13 && nRetry >= 3 && nRetry <= 4, "link lost");
        apb(1'b1, CSL_OFS_CTRL, 32'h0000_0000);
        wait_count(70);
        chk(nRetry == 0, "retry disabled");
        $display("Test flash and requests done");
        apb(1'b1, CSL_OFS_IRQ_STATUS, 32'h0000_000F);
        apb(1'b1, CSL_OFS_IRQ_MASK, 32'h0000_0004);
        cond(8'h55);
        @(posedge clock);
        lampClear <= 1'b1;
        @(posedge clock);
        lampClear <= 1'b0;
        for (int i = 0; i < 60; i++)
        begin
            frameStrobe <= ~frameStrobe;
            @(posedge clock);
        end
        frameStrobe <= 1'b0;
        repeat (14) @(posedge clock);
        @(negedge clock);
        chk(greenRises >= 8'd4 && greenRises <= 8'd6 && irq === 1'b1, "frame flash gap");
        apb(1'b1, CSL_OFS_IRQ_STATUS, 32'h0000_0004);
        apb(1'b0, CSL_OFS_IRQ_STATUS, 32'h0000_0000);
        chk(rd[2] === 1'b0 && irq === 1'b0, "interrupt cleared");
        $display("Test acquisition done");
        test_done();
    end

    initial
    begin
        repeat (60000) @(posedge clock);
        num_errors++;
        test_done();
    end
endmodule : csl_status_led_bench
`default_nettype wire
